//--- common/uart_pkg.sv
// constants, field positions and carrier types for the serial element
// assumes one 25 MHz clock and a plain strobe register port
package uart_pkg;
    localparam logic [2:0] ADDR_BUFFER   = 3'h0; // rx read, tx write
    localparam logic [2:0] ADDR_IRQ_EN   = 3'h1;
    localparam logic [2:0] ADDR_IRQ_ID   = 3'h2;
    localparam logic [2:0] ADDR_LINE_CTL = 3'h3;
    localparam logic [2:0] ADDR_MODEM_CTL = 3'h4;
    localparam logic [2:0] ADDR_LINE_ST  = 3'h5;
    localparam logic [2:0] ADDR_MODEM_ST = 3'h6;
    localparam logic [2:0] ADDR_SCRATCH  = 3'h7;
    localparam logic [2:0] ADDR_DIV_LOW  = 3'h0; // when access bit set
    localparam logic [2:0] ADDR_DIV_HIGH = 3'h1;
    localparam int LCR_ACCESS  = 7;
    localparam int LCR_STOP    = 2;
    localparam int MCR_DTR     = 0;
    localparam int MCR_RTS     = 1;
    localparam int MCR_OUTA    = 2;
    localparam int MCR_OUTB    = 3;
    localparam int MCR_LOOP    = 4;
    localparam int IER_MODEM   = 3;
    localparam logic [15:0] DIV_RESET = 16'h0001;
    localparam logic [3:0]  OVERSAMPLE = 4'hf; // 16 ticks per bit
    localparam logic [3:0]  HALF_BIT   = 4'h7;
    localparam logic [7:0]  LCR_RESET  = 8'h03;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } bus_req_type;

    typedef struct packed {
        logic ctsN;
        logic dsrN;
        logic riN;
        logic dcdN;
    } modem_in_type;

    typedef struct packed {
        logic dtrN;
        logic rtsN;
        logic outAN;
        logic outBN;
    } modem_out_type;

    typedef enum logic [3:0] {
        RX_IDLE  = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA  = 4'b0100,
        RX_STOP  = 4'b1000
    } rx_state_type;

    typedef enum logic [3:0] {
        TX_IDLE  = 4'b0001,
        TX_START = 4'b0010,
        TX_DATA  = 4'b0100,
        TX_STOP  = 4'b1000
    } tx_state_type;
endpackage : uart_pkg

//--- rtl/uart_modem_status_baud_buffers.sv
// modem status, baud divisor, receive buffer, transmit holding, scratch
// assumes a synchronous serial input, modem pins are synchronised; reads answered one cycle after the read strobe
module uart_modem_status_baud_buffers (
    input  wire logic                   ref_clk,   // 25 MHz clock
    input  wire logic                   sys_rst,   // async reset, high
    input  wire uart_pkg::bus_req_type  busReq,    // register request
    output logic [7:0]                  rdData,    // read data, next cycle
    input  wire logic                   serialIn,  // serial line in
    output logic                        serialOut, // serial line out
    input  wire uart_pkg::modem_in_type modemIn,   // active-low modem pins
    output uart_pkg::modem_out_type     modemOut,  // active-low controls
    output logic                        irqOutput  // interrupt, high
);
    import uart_pkg::*;

    typedef struct packed {
        logic [7:0]    rdData;
        logic [3:0]    sync1;
        logic [3:0]    sync2;
        logic [3:0]    prevState;
        logic [3:0]    delta;
        logic [3:0]    pendSet;
        logic [3:0]    pendClr;
        logic [15:0]   divisor;
        logic [15:0]   baudCnt;
        logic          tick;
        logic [7:0]    lineCtl;
        logic [4:0]    modemCtl;
        logic [3:0]    irqEn;
        logic [7:0]    scratch;
        logic [7:0]    rxBuf;
        logic          dataReady;
        logic          overrun;
        logic          framing;
        rx_state_type  rxState;
        logic [3:0]    rxTick;
        logic [2:0]    rxBit;
        logic [7:0]    rxShift;
        logic [7:0]    txHold;
        logic          holdFull;
        tx_state_type  txState;
        logic [3:0]    txTick;
        logic [2:0]    txBit;
        logic [7:0]    txShift;
        logic          txLine;
        logic          serialOut;
        logic [3:0]    modemOutN;
        logic          irq;
    } state_type;

    state_type s_q;
    state_type s_d;

    logic [3:0] pinState;
    logic [3:0] loopState;
    logic [3:0] curState;
    logic [3:0] change;
    logic [3:0] flagSet;
    logic       msRead;
    logic       lsRead;
    logic       divAccess;
    logic       rxIn;
    logic [2:0] lastBit;
    logic       rxBufRead;
    logic       rxDone;

    always_comb begin
        s_d       = s_q;
        divAccess = s_q.lineCtl[LCR_ACCESS];
        lastBit   = 3'(4 + s_q.lineCtl[1:0]);
        msRead    = busReq.rd && busReq.addr == ADDR_MODEM_ST;
        lsRead    = busReq.rd && busReq.addr == ADDR_LINE_ST;
        rxBufRead = busReq.rd && busReq.addr == ADDR_BUFFER && !divAccess;
        // order {dcd, ri, dsr, cts} so bit index matches the flag position
        pinState  = ~{s_q.sync2[0], s_q.sync2[1], s_q.sync2[2],
                      s_q.sync2[3]};
        loopState = {s_q.modemCtl[MCR_OUTB], s_q.modemCtl[MCR_OUTA],
                     s_q.modemCtl[MCR_DTR], s_q.modemCtl[MCR_RTS]};
        curState  = s_q.modemCtl[MCR_LOOP] ? loopState : pinState;
        change    = curState ^ s_q.prevState;
        // ring flag on the trailing edge of the active-low ring pin only
        change[2] = s_q.prevState[2] & ~curState[2];
        s_d.prevState = curState;

        // two-stage synchroniser: stage one feeds stage two only
        s_d.sync1 = modemIn;
        s_d.sync2 = s_q.sync1;

        // change flags with read collision handling
        flagSet = change;
        if (msRead) begin
            // a read one cycle long: the read end is the next edge
            s_d.pendSet = change & ~s_q.delta;
            s_d.pendClr = change & s_q.delta;
            s_d.delta   = 4'h0;
        end else begin
            s_d.delta   = (s_q.delta | flagSet | s_q.pendSet)
                          & ~s_q.pendClr;
            s_d.pendSet = 4'h0;
            s_d.pendClr = 4'h0;
        end

        // baud generator, one tick pulse per divisor count
        s_d.tick = 1'b0;
        if (s_q.baudCnt <= 16'h0001) begin
            s_d.baudCnt = s_q.divisor;
            s_d.tick    = 1'b1;
        end else begin
            s_d.baudCnt = s_q.baudCnt - 16'h0001;
        end

        // register writes
        if (busReq.wr) begin
            case (busReq.addr)
                ADDR_BUFFER: begin
                    if (divAccess) begin
                        s_d.divisor[7:0] = busReq.wdata;
                        s_d.baudCnt = {s_q.divisor[15:8],
                                       busReq.wdata};
                    end else begin
                        s_d.txHold   = busReq.wdata;
                        s_d.holdFull = 1'b1;
                    end
                end
                ADDR_IRQ_EN: begin
                    if (divAccess) begin
                        s_d.divisor[15:8] = busReq.wdata;
                        s_d.baudCnt = {busReq.wdata,
                                       s_q.divisor[7:0]};
                    end else begin
                        s_d.irqEn = busReq.wdata[3:0];
                    end
                end
                ADDR_LINE_CTL:  s_d.lineCtl  = busReq.wdata;
                ADDR_MODEM_CTL: s_d.modemCtl = busReq.wdata[4:0];
                ADDR_SCRATCH:   s_d.scratch  = busReq.wdata;
                default: ;
            endcase
        end

        // receiver; loop takes the transmit shifter's line instead
        rxIn = s_q.modemCtl[MCR_LOOP] ? s_q.txLine : serialIn;
        rxDone = s_q.tick && s_q.rxState == RX_STOP
                 && s_q.rxTick == OVERSAMPLE;
        if (s_q.tick) begin
            s_d.rxTick = s_q.rxTick + 4'h1;
            case (s_q.rxState)
                RX_IDLE: begin
                    s_d.rxTick = 4'h0;
                    if (!rxIn) begin
                        s_d.rxState = RX_START;
                    end
                end
                RX_START: begin
                    if (s_q.rxTick == HALF_BIT) begin
                        s_d.rxTick = 4'h0;
                        s_d.rxBit  = 3'h0;
                        s_d.rxShift = 8'h00;
                        s_d.rxState = rxIn ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (s_q.rxTick == OVERSAMPLE) begin
                        // shift in from the top so bit 0 is first
                        s_d.rxShift = {rxIn, s_q.rxShift[7:1]};
                        s_d.rxBit = s_q.rxBit + 3'h1;
                        if (s_q.rxBit == lastBit) begin
                            s_d.rxState = RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (s_q.rxTick == OVERSAMPLE) begin
                        // right-justify short characters, zero above
                        s_d.rxBuf = s_q.rxShift >>
                                    (3'h7 - lastBit);
                        s_d.overrun = s_q.overrun
                                      | s_q.dataReady;
                        s_d.dataReady = 1'b1;
                        s_d.framing = s_q.framing | ~rxIn;
                        s_d.rxState = RX_IDLE;
                    end
                end
                default: s_d.rxState = RX_IDLE;
            endcase
        end
        if (rxBufRead && !rxDone) begin
            s_d.dataReady = 1'b0;
        end
        if (lsRead) begin
            // a condition in the read cycle posts unless already set
            s_d.overrun = rxDone && s_q.dataReady
                          && !s_q.overrun;
            s_d.framing = rxDone && !rxIn && !s_q.framing;
        end

        // transmitter, same word length as receiver; only the transmitter uses the stop setting
        if (s_q.txState == TX_IDLE && s_q.holdFull) begin
            s_d.txShift  = s_q.txHold;
            s_d.holdFull = busReq.wr && busReq.addr == ADDR_BUFFER
                           && !divAccess;
            s_d.txState  = TX_START;
            s_d.txTick   = 4'h0;
        end else if (s_q.tick) begin
            s_d.txTick = s_q.txTick + 4'h1;
            case (s_q.txState)
                TX_START: begin
                    s_d.txLine = 1'b0;
                    if (s_q.txTick == OVERSAMPLE) begin
                        s_d.txBit = 3'h0;
                        s_d.txState = TX_DATA;
                    end
                end
                TX_DATA: begin
                    s_d.txLine = s_q.txShift[0];
                    if (s_q.txTick == OVERSAMPLE) begin
                        s_d.txShift = {1'b0, s_q.txShift[7:1]};
                        s_d.txBit = s_q.txBit + 3'h1;
                        // bits above the word length are never sent
                        if (s_q.txBit == lastBit) begin
                            s_d.txState = TX_STOP;
                            s_d.txBit = 3'h0;
                        end
                    end
                end
                TX_STOP: begin
                    s_d.txLine = 1'b1;
                    if (s_q.txTick == OVERSAMPLE) begin
                        s_d.txBit = s_q.txBit + 3'h1;
                        if (!s_q.lineCtl[LCR_STOP] || s_q.txBit != 3'h0) begin
                            s_d.txState = TX_IDLE;
                        end
                    end
                end
                default: s_d.txLine = 1'b1;
            endcase
        end
        s_d.serialOut = s_q.modemCtl[MCR_LOOP] ? 1'b1 : s_q.txLine;
        s_d.modemOutN = s_q.modemCtl[MCR_LOOP] ? 4'hf
                        : ~s_q.modemCtl[3:0];

        // only interrupt source in this block: modem status change
        s_d.irq = s_q.irqEn[IER_MODEM] && (|s_q.delta);

        // read data, valid the cycle after the strobe
        s_d.rdData = 8'h00;
        if (busReq.rd) begin
            case (busReq.addr)
                ADDR_BUFFER: s_d.rdData = divAccess ? s_q.divisor[7:0]
                                                    : s_q.rxBuf;
                ADDR_IRQ_EN: s_d.rdData = divAccess ? s_q.divisor[15:8]
                                                    : {4'h0, s_q.irqEn};
                ADDR_IRQ_ID: s_d.rdData = (s_q.irqEn[IER_MODEM]
                                           && |s_q.delta) ? 8'h00 : 8'h01;
                ADDR_LINE_CTL:  s_d.rdData = s_q.lineCtl;
                ADDR_MODEM_CTL: s_d.rdData = {3'h0, s_q.modemCtl};
                ADDR_LINE_ST: s_d.rdData = {1'b0,
                    !s_q.holdFull && s_q.txState == TX_IDLE,
                    !s_q.holdFull, 1'b0, s_q.framing, 1'b0, s_q.overrun,
                    s_q.dataReady};
                ADDR_MODEM_ST: s_d.rdData = {curState,
                                             s_q.delta};
                ADDR_SCRATCH: s_d.rdData = s_q.scratch;
                default: s_d.rdData = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_q <= '0;
            s_q.sync1 <= 4'hf;
            s_q.sync2 <= 4'hf;
            s_q.divisor <= DIV_RESET;
            s_q.baudCnt <= DIV_RESET;
            s_q.lineCtl <= LCR_RESET;
            s_q.rxState <= RX_IDLE;
            s_q.txState <= TX_IDLE;
            s_q.txLine <= 1'b1;
            s_q.serialOut <= 1'b1;
            s_q.modemOutN <= 4'hf;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdData    = s_q.rdData;
    assign serialOut = s_q.serialOut;
    assign modemOut  = {s_q.modemOutN[0], s_q.modemOutN[1],
                        s_q.modemOutN[2], s_q.modemOutN[3]};
    assign irqOutput = s_q.irq;
endmodule : uart_modem_status_baud_buffers

//--- sim/modem_baud_asserts.sv
// checker for modem status reads, interrupt, loop idle and bit timing
// assumes it is bound to the top module and sees only its ports
module modem_baud_asserts (
    input wire logic                    ref_clk,   // clock
    input wire logic                    sys_rst,   // reset, high
    input wire uart_pkg::bus_req_type   busReq,    // register request
    input wire logic [7:0]              rdData,    // read data
    input wire logic                    serialIn,  // line in
    input wire logic                    serialOut, // line out
    input wire uart_pkg::modem_in_type  modemIn,   // modem pins
    input wire uart_pkg::modem_out_type modemOut,  // modem controls
    input wire logic                    irqOutput  // interrupt
);
    timeunit 1ns;
    timeprecision 1ns;
    import uart_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // shadow of the writes that steer what the design must show
    modem_in_type prevInQ;
    logic [3:0]   ageQ;
    logic [4:0]   mcrQ;
    logic         ierQ;
    logic         dlabQ;
    logic [15:0]  divQ;
    logic [19:0]  lowRunQ;
    wire          loop = mcrQ[MCR_LOOP];
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prevInQ <= '1;
            ageQ <= 4'h0;
            mcrQ <= 5'h00;
            ierQ <= 1'b0;
            dlabQ <= 1'b0;
            divQ <= DIV_RESET;
            lowRunQ <= 20'h0;
        end else begin
            prevInQ <= modemIn;
            lowRunQ <= serialOut ? 20'h0 : lowRunQ + 20'h1;
            // age restarts on any write or pin change, saturating at 15
            if (busReq.wr || modemIn != prevInQ) ageQ <= 4'h0;
            else if (ageQ != 4'hf) ageQ <= ageQ + 4'h1;
            if (busReq.wr) begin
                case (busReq.addr)
                    ADDR_LINE_CTL: dlabQ <= busReq.wdata[LCR_ACCESS];
                    ADDR_MODEM_CTL: mcrQ <= busReq.wdata[4:0];
                    ADDR_DIV_LOW: if (dlabQ) divQ[7:0] <= busReq.wdata;
                    ADDR_DIV_HIGH: if (dlabQ) divQ[15:8] <= busReq.wdata;
                        else ierQ <= busReq.wdata[IER_MODEM];
                    default: ;
                endcase
            end
        end
    end
    sequence s_quiet_rd;
        busReq.rd && busReq.addr == ADDR_MODEM_ST && ageQ >= 4'h6
            && $stable(modemIn);
    endsequence
    sequence s_still;
        $stable(modemIn) && !busReq.wr;
    endsequence
    property p_state_pins;
        s_quiet_rd ##0 !loop |=> rdData[7:4] ==
            ~{prevInQ.dcdN, prevInQ.riN, prevInQ.dsrN, prevInQ.ctsN};
    endproperty
    a_state_pins: assert property (p_state_pins)
        else $error("modem state bits differ from pins");
    property p_state_loop;
        s_quiet_rd ##0 loop |=> rdData[7:4] == {mcrQ[MCR_OUTB],
            mcrQ[MCR_OUTA], mcrQ[MCR_DTR], mcrQ[MCR_RTS]};
    endproperty
    a_state_loop: assert property (p_state_loop)
        else $error("loop state bits differ from controls");
    property p_flag_clear;
        s_quiet_rd ##2 s_quiet_rd |=> rdData[3:0] == 4'h0;
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("change flags survived a status read");
    property p_irq_off;
        s_quiet_rd |-> ##2 !irqOutput;
    endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("interrupt stayed after status read");
    property p_irq_set;
        ierQ && !loop && ageQ >= 4'h6 && (|((modemIn ^ prevInQ) & 4'hd)
            || $rose(modemIn.riN)) |-> ##[1:5] irqOutput;
    endproperty
    a_irq_set: assert property (p_irq_set)
        else $error("pin change raised no interrupt");
    property p_ring_fall;
        ierQ && !loop && ageQ >= 4'h6 && !irqOutput && !modemIn.riN
            && (modemIn ^ prevInQ) == 4'h2 ##1 s_still [*5] |-> !irqOutput;
    endproperty
    a_ring_fall: assert property (p_ring_fall)
        else $error("ring pin fall raised interrupt");
    property p_loop_idle;
        loop && ageQ >= 4'h2 |-> serialOut && modemOut == 4'hf;
    endproperty
    a_loop_idle: assert property (p_loop_idle)
        else $error("loop mode outputs not idle");
    property p_bit_time;
        $rose(serialOut) && !loop |-> lowRunQ % {divQ, 4'h0} == 20'h0;
    endproperty
    a_bit_time: assert property (p_bit_time)
        else $error("low run not whole bit times");
endmodule : modem_baud_asserts

bind uart_modem_status_baud_buffers modem_baud_asserts modem_baud_asserts_i (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .busReq(busReq),
    .rdData(rdData), .serialIn(serialIn), .serialOut(serialOut),
    .modemIn(modemIn), .modemOut(modemOut), .irqOutput(irqOutput)
);

//--- sim/modem_link_model.sv
// far side: modem pins and serial line partner
// assumes the bench hands in the bit length in clock cycles
module modem_link_model (
    input  wire logic               ref_clk,   // clock
    input  wire logic               serialOut, // line from design
    output uart_pkg::modem_in_type  modemIn,   // active-low pins
    output logic                    serialIn   // line to design
);
    timeunit 1ns;
    timeprecision 1ns;
    import uart_pkg::*;
    initial begin
        modemIn = '1;
        serialIn = 1'b1;
    end
    task automatic setPins(input modem_in_type m);
        @(posedge ref_clk);
        modemIn <= m;
    endtask : setPins
    task automatic sendChar(input logic [7:0] d, input int bitLen);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge ref_clk);
            serialIn <= f[i];
            repeat (bitLen - 1) @(posedge ref_clk);
        end
    endtask : sendChar
    // sample mid-bit so no sample lands on a launching edge
    task automatic getChar(input int bitLen, output logic [7:0] d);
        @(negedge serialOut);
        repeat (bitLen / 2) @(posedge ref_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (bitLen) @(posedge ref_clk);
            d[i] = serialOut;
        end
    endtask : getChar
endmodule : modem_link_model

//--- sim/uart_modem_status_baud_buffers_tb.sv
// bench for modem status, divisor, buffers and scratch register
// assumes the link model and the bound checker are compiled before it
module uart_modem_status_baud_buffers_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import uart_pkg::*;
    typedef struct packed {
        logic       wr;
        logic [2:0] addr;
        logic [7:0] data;
    } row_type;
    // write or read-and-expect rows: wr, addr, data
    localparam row_type ROWS [13] = '{12'hfa5, 12'h7a5, 12'hf5a, 12'h75a,
        12'hb83, 12'h834, 12'h912, 12'h034, 12'h112, 12'h900, 12'h801,
        12'hb03, 12'h75a};
    logic          ref_clk;
    logic          sys_rst;
    bus_req_type   busReq;
    logic [7:0]    rdData;
    logic [7:0]    got;
    logic          serialIn;
    logic          serialOut;
    logic          irqOutput;
    modem_in_type  modemIn;
    modem_out_type modemOut;
    int            fails = 0;
    int            num_checks = 0;
    int            cycles = 0;
    uart_modem_status_baud_buffers uart_modem_status_baud_buffers_i (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .busReq(busReq),
        .rdData(rdData), .serialIn(serialIn), .serialOut(serialOut),
        .modemIn(modemIn), .modemOut(modemOut), .irqOutput(irqOutput));
    modem_link_model modem_link_model_i (.ref_clk(ref_clk),
        .serialOut(serialOut), .modemIn(modemIn), .serialIn(serialIn));
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 10000) begin
            fails++;
            tally_and_finish();
        end
    end
    task automatic cmp(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask : cmp
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        busReq <= '0;
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        busReq <= '0;
        #1 d = rdData;
    endtask : rd
    task automatic chk(input logic [2:0] a, input logic [7:0] e);
        rd(a, got);
        cmp(got, e);
    endtask : chk
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : idle
    initial begin
        modem_in_type m;
        logic [3:0]   st;
        logic [3:0]   flg;
        int           p;
        sys_rst = 1'b1;
        busReq = '0;
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        #1 cmp({serialOut, irqOutput, 2'b00, modemOut}, 8'h8f);
        chk(ADDR_LINE_ST, 8'h60);
        chk(ADDR_MODEM_ST, 8'h00);
        foreach (ROWS[i]) begin
            if (ROWS[i].wr) wr(ROWS[i].addr, ROWS[i].data);
            else chk(ROWS[i].addr, ROWS[i].data);
        end
        wr(ADDR_IRQ_EN, 8'h08);
        m = '1;
        // each pin falls, then each rises; ring flags only on its rise
        for (int k = 0; k < 8; k++) begin
            p = k % 4;
            m[3 - p] = (k >= 4);
            modem_link_model_i.setPins(m);
            idle(6);
            st = ~{m[0], m[1], m[2], m[3]};
            flg = (p != 2 || k >= 4) ? 4'h1 << p : 4'h0;
            cmp({7'h00, irqOutput}, {7'h00, |flg});
            chk(ADDR_MODEM_ST, {st, flg});
            chk(ADDR_MODEM_ST, {st, 4'h0});
            idle(3);
        end
        // pin change lands in a status read: posted if the flag was low
        m.ctsN = 1'b0;
        fork
            modem_link_model_i.setPins(m);
            begin
                repeat (2) @(posedge ref_clk);
                rd(ADDR_MODEM_ST, got);
            end
        join
        cmp(got, 8'h10);
        chk(ADDR_MODEM_ST, 8'h11);
        m.ctsN = 1'b1;
        modem_link_model_i.setPins(m);
        idle(6);
        // flag already high: the colliding change is lost
        m.ctsN = 1'b0;
        fork
            modem_link_model_i.setPins(m);
            begin
                repeat (2) @(posedge ref_clk);
                rd(ADDR_MODEM_ST, got);
            end
        join
        cmp(got, 8'h11);
        chk(ADDR_MODEM_ST, 8'h10);
        m.ctsN = 1'b1;
        modem_link_model_i.setPins(m);
        idle(6);
        chk(ADDR_MODEM_ST, 8'h01);
        wr(ADDR_MODEM_CTL, 8'h1d);
        idle(6);
        cmp({serialOut, 3'h0, modemOut}, 8'h8f);
        chk(ADDR_MODEM_ST, 8'hea);
        wr(ADDR_MODEM_CTL, 8'h12);
        idle(6);
        chk(ADDR_MODEM_ST, 8'h1f);
        wr(ADDR_BUFFER, 8'ha5);
        idle(200);
        chk(ADDR_LINE_ST, 8'h61);
        chk(ADDR_BUFFER, 8'ha5);
        chk(ADDR_LINE_ST, 8'h60);
        wr(ADDR_BUFFER, 8'h11);
        idle(200);
        wr(ADDR_BUFFER, 8'h22);
        idle(200);
        chk(ADDR_LINE_ST, 8'h63);
        chk(ADDR_BUFFER, 8'h22);
        wr(ADDR_LINE_CTL, 8'h00);
        wr(ADDR_BUFFER, 8'hff);
        rd(ADDR_LINE_ST, got);
        cmp(got & 8'h40, 8'h00);
        idle(200);
        chk(ADDR_BUFFER, 8'h1f);
        wr(ADDR_LINE_CTL, 8'h03);
        wr(ADDR_MODEM_CTL, 8'h05);
        idle(2);
        cmp({4'h0, modemOut}, 8'h05);
        wr(ADDR_LINE_CTL, 8'h83);
        wr(ADDR_DIV_LOW, 8'h02);
        wr(ADDR_DIV_HIGH, 8'h00);
        wr(ADDR_LINE_CTL, 8'h03);
        modem_link_model_i.sendChar(8'h96, 32);
        idle(40);
        chk(ADDR_BUFFER, 8'h96);
        fork
            modem_link_model_i.getChar(32, got);
            wr(ADDR_BUFFER, 8'h3c);
        join
        cmp(got, 8'h3c);
        tally_and_finish();
    end
endmodule : uart_modem_status_baud_buffers_tb
